// ### src/sslc_top.sv
// Notes on behaviour
// RL1 - Serial data is taken into the shift register on each rising serial clock edge.
// RL2 - Words arrive MSB first and the last bit shifted in is the latch-select control bit.
// RL3 - A rising load strobe copies the shift register into the latch picked by the control bit.
// RL4 - The host keeps the serial clock low whenever the load strobe changes.
// RL5 - An undriven load strobe reads as high, as if pulled up.
// RL6 - A low polarity select swaps the pump sense; an undriven select reads as normal.
// RL7 - While the load strobe is high the pump output is also driven on the loop switch output.
// RL8 - In lock the lock indicator stays high apart from brief low pulses while the pump acts.
// RL9 - A phase comparator input is shown on a push-pull monitor output.
// RL10 - A load alters only the selected latch, and shifting alone alters no latch.
`timescale 1ns/1ps
`default_nettype none

module sslc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial load pins
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic load_strobe_driven,
    // Polarity select pin
    input wire logic phase_polarity_select,
    input wire logic phase_polarity_driven,
    // Phase comparator inputs
    input wire logic ref_phase_in,
    input wire logic rf_counter_input,
    // Pump and switch outputs
    output sslc_pkg::sslc_pump_t pump_out,
    output sslc_pkg::sslc_pump_t loop_switch_output,
    output logic loop_switch_oe,
    // Status pins
    output logic lock_indicator,
    output logic monitor_output,
    // Latch contents
    output sslc_pkg::sslc_latch_t latches,
    // Register port
    input wire logic [sslc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sslc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sslc_pkg::DATA_W-1:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    localparam int NPIN = 6;
    // Bit positions of the pins inside the synchronised group.
    localparam int PIN_SCLK = 5;
    localparam int PIN_SDATA = 4;
    localparam int PIN_STROBE = 3;
    localparam int PIN_POLARITY = 2;
    localparam int PIN_REF = 1;
    localparam int PIN_VCO = 0;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_sync;
    wire strobe_pin;
    wire polarity_pin;

    // Undriven pulled-up pins resolve high before they are sampled.
    assign strobe_pin = load_strobe_driven ? load_strobe : 1'h1; // [RL5]
    assign polarity_pin = phase_polarity_driven ? phase_polarity_select : 1'h1; // [RL6]
    // The pulled-up pins travel inverted, so the cleared synchroniser reads
    // them at their idle high level. A strobe held high through reset then
    // shows no false rising edge, and the pump starts with normal sense.
    assign pin_raw = {serial_clock, serial_data, ~strobe_pin, ~polarity_pin,
                      ref_phase_in, rf_counter_input};

    sslc_sync #(.W(NPIN)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    wire sclk_s;
    wire sdata_s;
    wire strobe_s;
    wire polarity_s;
    wire ref_s;
    wire vco_s;

    // Named views of the synchronised pins; the pulled-up pair is turned back.
    assign sclk_s = pin_sync[PIN_SCLK];
    assign sdata_s = pin_sync[PIN_SDATA];
    assign strobe_s = ~pin_sync[PIN_STROBE]; // [RL5]
    assign polarity_s = ~pin_sync[PIN_POLARITY]; // [RL6]
    assign ref_s = pin_sync[PIN_REF];
    assign vco_s = pin_sync[PIN_VCO];

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    logic sclk_d;
    logic strobe_d;
    logic ref_d;
    logic vco_d;
    wire sclk_rise;
    wire strobe_rise;
    wire ref_edge;
    wire vco_edge;

    // Delayed copies of the synchronised levels.
    // The strobe history starts high, matching the idle level of its pin.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d <= 1'h0;
            strobe_d <= 1'h1;
            ref_d <= 1'h0;
            vco_d <= 1'h0;
        end else begin
            sclk_d <= sclk_s;
            strobe_d <= strobe_s;
            ref_d <= ref_s;
            vco_d <= vco_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;
    assign strobe_rise = strobe_s & ~strobe_d;
    assign ref_edge = ref_s & ~ref_d;
    assign vco_edge = vco_s & ~vco_d;

    // ----------------------------------------------------------------
    // Shift register and latches
    // ----------------------------------------------------------------
    logic [sslc_pkg::WORD_W-1:0] shreg;
    wire [sslc_pkg::WORD_W-1:0] next_shreg;
    wire load_ref;
    wire load_cnt;
    wire ctrl_bit;

    // New bits enter at the bottom so the first bit ends at the top.
    assign next_shreg = {shreg[sslc_pkg::WORD_W-2:0], sdata_s}; // [RL2]
    assign ctrl_bit = shreg[sslc_pkg::CTRL_BIT]; // [RL2]
    // The host keeps the clock low across strobe edges, so no shift collides.
    assign load_ref = strobe_rise & (ctrl_bit == sslc_pkg::CTRL_REF); // [RL3] [RL4]
    assign load_cnt = strobe_rise & (ctrl_bit == sslc_pkg::CTRL_CNT); // [RL3]

    // Shift on each rising serial clock edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg <= '0;
        end else if (sclk_rise) begin
            shreg <= next_shreg; // [RL1]
        end
    end

    // Each latch loads only when selected; shifting leaves both alone.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latches.ref_value <= sslc_pkg::LATCH_RESET;
            latches.cnt_value <= sslc_pkg::LATCH_RESET;
        end else begin
            if (load_ref) begin
                latches.ref_value <= shreg[sslc_pkg::WORD_W-1:1]; // [RL3] [RL10]
            end
            if (load_cnt) begin
                latches.cnt_value <= shreg[sslc_pkg::WORD_W-1:1]; // [RL3] [RL10]
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase comparator and pump
    // ----------------------------------------------------------------
    logic pd_up;
    logic pd_down;
    wire pend_up;
    wire pend_down;
    wire pd_both;
    wire next_pd_up;
    wire next_pd_down;
    sslc_pkg::sslc_pump_t next_pump;

    // Either input edge opens its side; both open means both reset.
    assign pend_up = pd_up | ref_edge;
    assign pend_down = pd_down | vco_edge;
    assign pd_both = pend_up & pend_down;
    assign next_pd_up = pend_up & ~pd_both;
    assign next_pd_down = pend_down & ~pd_both;
    // A low select swaps the combined comparator and pump sense.
    assign next_pump.up = polarity_s ? next_pd_up : next_pd_down; // [RL6]
    assign next_pump.down = polarity_s ? next_pd_down : next_pd_up; // [RL6]

    // Comparator state and registered pump drive.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_up <= 1'h0;
            pd_down <= 1'h0;
            pump_out <= '0;
        end else begin
            pd_up <= next_pd_up;
            pd_down <= next_pd_down;
            pump_out <= next_pump;
        end
    end

    // The switch closes while the strobe is high and carries the pump.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loop_switch_output <= '0;
            loop_switch_oe <= 1'h0;
        end else begin
            loop_switch_output <= strobe_s ? next_pump : '0; // [RL7]
            loop_switch_oe <= strobe_s; // [RL7]
        end
    end

    // ----------------------------------------------------------------
    // Lock detection
    // ----------------------------------------------------------------
    logic [sslc_pkg::GAP_W-1:0] gap;
    logic [sslc_pkg::STREAK_W-1:0] streak;
    logic locked;
    wire one_side;
    wire hit;
    wire next_locked;
    wire [sslc_pkg::STREAK_W-1:0] next_streak;

    // Gap counts cycles while only one side is pending.
    // The gap is one less than the spacing of the two edges, so a pair
    // whose edges lie up to six cycles apart still counts as a hit.
    assign one_side = pd_up ^ pd_down;
    assign hit = gap <= sslc_pkg::GAP_WIN;
    assign next_streak = !pd_both ? streak
        : !hit ? '0
        : (streak == sslc_pkg::LOCK_STREAK) ? streak
        : streak + 3'h1;
    assign next_locked = next_streak == sslc_pkg::LOCK_STREAK;

    // Coincidence counting over successive comparisons.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap <= '0;
            streak <= '0;
            locked <= 1'h0;
        end else begin
            if (pd_both) begin
                gap <= '0;
            end else if (one_side && gap != sslc_pkg::GAP_MAX) begin
                gap <= gap + 8'h01;
            end
            streak <= next_streak;
            locked <= next_locked;
        end
    end

    // Indicator high in lock, dipping low while the pump is active.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_indicator <= 1'h0;
        end else begin
            lock_indicator <= next_locked & ~(next_pd_up | next_pd_down); // [RL8]
        end
    end

    // ----------------------------------------------------------------
    // Monitor output
    // ----------------------------------------------------------------
    wire mon_sel;

    assign mon_sel = latches.cnt_value[sslc_pkg::MON_SEL_BIT];

    // Push-pull copy of the chosen comparator input.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            monitor_output <= 1'h0;
        end else begin
            monitor_output <= mon_sel ? vco_s : ref_s; // [RL9]
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    function automatic logic addr_is(input logic [sslc_pkg::ADDR_W-1:0] a,
                                     input logic [sslc_pkg::ADDR_W-1:0] off);
        addr_is = (a == off);
    endfunction

    sslc_pkg::sslc_evt_t status;
    logic [sslc_pkg::EVT_W-1:0] enable;
    sslc_pkg::sslc_evt_t evt;
    wire [sslc_pkg::EVT_W-1:0] clr;
    wire [sslc_pkg::EVT_W-1:0] next_status;

    assign evt.lock_lost = locked & ~next_locked;
    assign evt.lock_gained = ~locked & next_locked;
    assign evt.cnt_loaded = load_cnt;
    assign evt.ref_loaded = load_ref;
    assign clr = (reg_wr && addr_is(reg_addr, sslc_pkg::OFF_CLEAR))
        ? reg_wdata[sslc_pkg::EVT_W-1:0] : '0;
    // A set in the same cycle as its clear wins.
    assign next_status = (status & ~clr) | evt;

    // Sticky status, enable and level interrupt.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= sslc_pkg::EVT_RESET;
            enable <= sslc_pkg::EVT_RESET;
            irq <= 1'h0;
        end else begin
            status <= next_status;
            if (reg_wr && addr_is(reg_addr, sslc_pkg::OFF_ENABLE)) begin
                enable <= reg_wdata[sslc_pkg::EVT_W-1:0];
            end
            irq <= |(next_status & enable);
        end
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    wire [sslc_pkg::DATA_W-1:0] rd_mux;

    assign rd_mux = addr_is(reg_addr, sslc_pkg::OFF_STATUS)
        ? {{(sslc_pkg::DATA_W - sslc_pkg::EVT_W){1'h0}}, status}
        : addr_is(reg_addr, sslc_pkg::OFF_ENABLE)
        ? {{(sslc_pkg::DATA_W - sslc_pkg::EVT_W){1'h0}}, enable}
        : addr_is(reg_addr, sslc_pkg::OFF_REF_LATCH)
        ? {{(sslc_pkg::DATA_W - sslc_pkg::VALUE_W){1'h0}}, latches.ref_value}
        : addr_is(reg_addr, sslc_pkg::OFF_CNT_LATCH)
        ? {{(sslc_pkg::DATA_W - sslc_pkg::VALUE_W){1'h0}}, latches.cnt_value}
        : '0;

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule

`default_nettype wire

// ### src/sslc_pkg.sv
package sslc_pkg;

    // ----------------------------------------------------------------
    // Serial word layout
    // ----------------------------------------------------------------
    localparam int WORD_W = 19;
    localparam int VALUE_W = WORD_W - 1;
    localparam int CTRL_BIT = 0;
    localparam logic CTRL_REF = 1'h1;
    localparam logic CTRL_CNT = 1'h0;
    localparam int MON_SEL_BIT = 0;
    localparam logic [VALUE_W-1:0] LATCH_RESET = 18'h00000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_WINDOW_NS = 50;
    localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS / CLK_PERIOD_NS > 0)
        ? LOCK_WINDOW_NS / CLK_PERIOD_NS : 1;
    localparam int GAP_W = 8;
    localparam logic [GAP_W-1:0] GAP_MAX = 8'hFF;
    localparam logic [GAP_W-1:0] GAP_WIN = GAP_W'(LOCK_WINDOW_CYC);
    localparam int STREAK_W = 3;
    localparam logic [STREAK_W-1:0] LOCK_STREAK = 3'h4;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_REF_LATCH = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CNT_LATCH = 8'h10;
    localparam int EVT_W = 4;
    localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic up;
        logic down;
    } sslc_pump_t;

    typedef struct packed {
        logic lock_lost;
        logic lock_gained;
        logic cnt_loaded;
        logic ref_loaded;
    } sslc_evt_t;

    typedef struct packed {
        logic [VALUE_W-1:0] ref_value;
        logic [VALUE_W-1:0] cnt_value;
    } sslc_latch_t;

endpackage

// ### src/sslc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a group of asynchronous levels.
module sslc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // Only the second stage reads the first stage.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// ### bench/sslc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module sslc_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pins
    input wire logic load_strobe,
    input wire logic load_strobe_driven,
    input wire logic ref_phase_in,
    input wire sslc_pkg::sslc_pump_t pump_out,
    input wire sslc_pkg::sslc_pump_t loop_switch_output,
    input wire logic loop_switch_oe,
    input wire logic monitor_output,
    input wire sslc_pkg::sslc_latch_t latches,
    // Register port
    input wire logic [sslc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [sslc_pkg::DATA_W-1:0] reg_rdata
);
    // Strobe level as the pin holds it, pull-up included.
    wire strobe = load_strobe | ~load_strobe_driven;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Switch state, switch data, latches, monitor and read data.
    property p_sw_on; strobe [*5] |-> loop_switch_oe; endproperty
    a_sw_on: assert property (p_sw_on) else $error("switch open");
    property p_sw_off; !strobe [*5] |-> !loop_switch_oe; endproperty
    a_sw_off: assert property (p_sw_off) else $error("switch closed");
    property p_sw_zero; !loop_switch_oe |-> loop_switch_output == 2'h0; endproperty
    a_sw_zero: assert property (p_sw_zero) else $error("open switch drives");
    property p_sw_copy; loop_switch_oe |-> loop_switch_output == pump_out; endproperty
    a_sw_copy: assert property (p_sw_copy) else $error("switch differs from pump");
    property p_hold; !strobe [*5] |-> $stable(latches); endproperty
    a_hold: assert property (p_hold) else $error("latch changed without load");
    property p_mon;
        (!latches.cnt_value[0] && $stable(ref_phase_in)) [*5] |-> monitor_output == ref_phase_in;
    endproperty
    a_mon: assert property (p_mon) else $error("monitor wrong");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rd_ref;
        $past(reg_rd) && $past(reg_addr) == sslc_pkg::OFF_REF_LATCH
            |-> reg_rdata == 32'($past(latches.ref_value));
    endproperty
    a_rd_ref: assert property (p_rd_ref) else $error("ref latch read wrong");
    c_load: cover property ($rose(loop_switch_oe));
    c_mon: cover property ($rose(monitor_output));
    c_pump: cover property (pump_out.up ##1 !pump_out.up);
endmodule

bind sslc_top sslc_top_chk i_chk (
    .clk(clk), .rst_b(rst_b), .load_strobe(load_strobe),
    .load_strobe_driven(load_strobe_driven), .ref_phase_in(ref_phase_in),
    .pump_out(pump_out), .loop_switch_output(loop_switch_output),
    .loop_switch_oe(loop_switch_oe), .monitor_output(monitor_output), .latches(latches),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

`default_nettype wire

// ### bench/sslc_host.sv
`timescale 1ns/1ps
`default_nettype none

module sslc_host (
    // Serial pins
    output logic serial_clock,
    output logic serial_data,
    output logic load_strobe,
    output logic load_strobe_driven
);
    // Idle link: clock still and low, strobe driven low.
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
        load_strobe_driven = 1'b1;
    end

    // Shifts a word; mode 0 no load, 1 strobe pulse, 2 strobe released to its pull-up.
    task automatic send(input logic [sslc_pkg::WORD_W-1:0] w, input int mode);
        load_strobe_driven = 1'b1;
        load_strobe = 1'b0;
        #62.5;
        for (int i = sslc_pkg::WORD_W - 1; i >= 0; i--) begin
            serial_data = w[i];
            #62.5 serial_clock = 1'b1;
            #62.5 serial_clock = 1'b0;
        end
        serial_data = ~serial_data;
        #62.5;
        if (mode == 1) begin
            load_strobe = 1'b1;
            #250 load_strobe = 1'b0;
        end
        // Released strobe keeps a low level so only the pull-up can lift it.
        if (mode == 2) load_strobe_driven = 1'b0;
    endtask
endmodule

`default_nettype wire

// ### bench/sslc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sslc_top_bench;
    // Design inputs, outputs and bench state.
    logic clk, rst_b, ref_in, rf_in, pol, pol_drv, reg_wr, reg_rd, en;
    logic sclk, sdat, lstb, lstb_drv, lsw_oe, lock, mon, irq;
    logic [sslc_pkg::ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [17:0] exp_ref, exp_cnt;
    sslc_pkg::sslc_pump_t pump, lsw;
    sslc_pkg::sslc_latch_t lat;
    integer seed = 32'h7D9E3ADE;
    int failures, tests_run;

    sslc_host i_host (.serial_clock(sclk), .serial_data(sdat), .load_strobe(lstb),
        .load_strobe_driven(lstb_drv));
    sslc_top i_dut (.clk(clk), .rst_b(rst_b), .serial_clock(sclk), .serial_data(sdat),
        .load_strobe(lstb), .load_strobe_driven(lstb_drv), .phase_polarity_select(pol),
        .phase_polarity_driven(pol_drv), .ref_phase_in(ref_in), .rf_counter_input(rf_in),
        .pump_out(pump), .loop_switch_output(lsw), .loop_switch_oe(lsw_oe),
        .lock_indicator(lock), .monitor_output(mon), .latches(lat), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq));

    // Expected pump drive: up when the leading input matches the polarity.
    function automatic logic [1:0] exp_pump(input logic p, input logic ref_first);
        return (ref_first == p) ? 2'h2 : 2'h1;
    endfunction

    // Compares and counts.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic summarize;
        $display("Checks %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One-cycle register write and read.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Sends a word, then checks event, interrupt and both latches.
    task automatic load(input logic [18:0] w, input int mode);
        i_host.send(w, mode);
        if (mode > 0 && w[0]) exp_ref = w[18:1];
        if (mode > 0 && !w[0]) exp_cnt = w[18:1];
        repeat (8) @(posedge clk);
        check("irq set", 32'(irq), 32'(en && mode > 0));
        rd(sslc_pkg::OFF_STATUS, d);
        check("status", d & 32'h3, mode == 0 ? 32'h0 : (w[0] ? 32'h1 : 32'h2));
        wr(sslc_pkg::OFF_CLEAR, 32'hF);
        repeat (2) @(posedge clk);
        #1 check("irq clear", 32'(irq), 32'h0);
        check("ref latch", 32'(lat.ref_value), 32'(exp_ref));
        rd(sslc_pkg::OFF_CNT_LATCH, d);
        check("cnt latch", d, 32'(exp_cnt));
        rd(sslc_pkg::OFF_REF_LATCH, d);
        check("ref latch read", d, 32'(exp_ref));
    endtask

    // One comparator pair, edges eight cycles apart so no lock builds up.
    task automatic phase(input logic p, input logic ref_first, input logic sw);
        pol <= 1'b0;
        pol_drv <= ~p;
        repeat (4) @(posedge clk);
        ref_in <= ref_first;
        rf_in <= ~ref_first;
        repeat (5) @(posedge clk);
        #1 check("pump", 32'(pump), 32'(exp_pump(p, ref_first)));
        check("switch", 32'(lsw), sw ? 32'(exp_pump(p, ref_first)) : 32'h0);
        check("monitor", 32'(mon), 32'(ref_first ^ exp_cnt[0]));
        check("switch on", 32'(lsw_oe), 32'(sw));
        repeat (3) @(posedge clk);
        ref_in <= 1'b1;
        rf_in <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check("pump idle", 32'(pump), 32'h0);
        @(posedge clk);
        ref_in <= 1'b0;
        rf_in <= 1'b0;
    endtask

    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog against a hang.
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        summarize();
    end

    // Main sequence.
    initial begin
        {rst_b, ref_in, rf_in, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {pol, pol_drv, en, exp_ref, exp_cnt, failures, tests_run} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        wr(sslc_pkg::OFF_STATUS, 32'hFFFFFFFF);
        for (int a = 0; a <= 20; a += 4) begin
            rd(8'(a), d);
            check("reset read", d, 32'h0);
        end
        wr(sslc_pkg::OFF_ENABLE, 32'h3);
        en = 1'b1;
        for (int k = 0; k < 6; k++) begin
            // All-ones words into each latch first, then random words.
            load(k == 0 ? 19'h7FFFF : k == 1 ? 19'h7FFFE : 19'($random(seed)), 1);
        end
        load(19'($random(seed)), 0);
        wr(sslc_pkg::OFF_ENABLE, 32'h0);
        en = 1'b0;
        load(19'($random(seed)), 1);
        for (int k = 0; k < 8; k++) begin
            if (k == 4) load(19'($random(seed)), 2);
            phase(k[0], k[1], k[2]);
        end
        // Pairs eight cycles apart must not have built a lock.
        check("no lock", 32'(lock), 32'h0);
        @(posedge clk);
        for (int n = 0; n < 6; n++) begin
            ref_in <= 1'b1;
            repeat (2) @(posedge clk);
            rf_in <= 1'b1;
            repeat (6) @(posedge clk);
            ref_in <= 1'b0;
            rf_in <= 1'b0;
            repeat (6) @(posedge clk);
        end
        #1 check("lock", 32'(lock), 32'h1);
        rd(sslc_pkg::OFF_STATUS, d);
        check("lock event", d & 32'h4, 32'h4);
        summarize();
    end
endmodule

`default_nettype wire
